// file: countdown_timer.sv
/*
  Periodic countdown timer with a 12-bit preset, status flags, interrupt
  status and mask, password write protection and an APB slave port.
  Assumes an APB master on CLK and single-cycle event pulses on FLAG_EVENTS.
*/
// Implementation choice: the APB interface to the registers.
// Operation
// RL1: low preset register holds preset bits 7:0, any value 00h to ffh
// RL2: high preset register holds preset bits 11:8 in its bits 3:0
// RL3: high preset bits 7:4 always read zero, writes there ignored
// RL4: at zero the counter reloads the stored preset by itself
// RL5: reload makes the timer interrupt once per period, repeatedly
// RL6: period equals preset divided by selected timer clock rate
// RL7: presets always readable; writes blocked while password protection active
// RL8: status flags set only by their events; software reads or clears
// RL9: expiry sets timer flag, kept until zero written; one keeps it
// RL10: preset reads return stored preset, never the running count
`timescale 1ns/1ps
module countdown_timer
  import countdown_timer_pkg::*;
#(
  parameter int unsigned        FAST_DIV = CLK_HZ / FAST_HZ,
  parameter int unsigned        SLOW_DIV = CLK_HZ / SLOW_HZ,
  parameter logic [DATA_W-1:0]  PASSWORD = 32'h5a5a_a5a5 // arbitrary value
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  input  wire logic [FLAG_W-1:0] FLAG_EVENTS,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic                   IRQ
);
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic is_guarded(input logic [5:0] idx);
    return idx == IDX_PRESET_LO || idx == IDX_PRESET_HI || idx == IDX_FLAGS ||
           idx == IDX_CTRL;
  endfunction

  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // register state
  logic [LO_W-1:0]     preset_lo;
  logic [HI_W-1:0]     preset_hi;
  logic [CTRL_W-1:0]   ctrl;
  logic [DATA_W-1:0]   pw_entry;
  logic [FLAG_W-1:0]   irq_mask;
  logic [LO_W-1:0]     next_preset_lo;
  logic [HI_W-1:0]     next_preset_hi;
  logic [CTRL_W-1:0]   next_ctrl;
  logic [DATA_W-1:0]   next_pw_entry;
  logic [FLAG_W-1:0]   next_irq_mask;
  logic [FLAG_W-1:0]   flags;
  logic [FLAG_W-1:0]   irq_status;
  logic [PRESET_W-1:0] count;
  logic [5:0]          idx;
  logic                locked;
  logic                wr_en;
  logic                wr_ok;
  logic                flags_wr;
  logic                irq_wr;

  assign idx      = reg_index(PADDR);
  assign locked   = ctrl[CTRL_PROT] && (pw_entry != PASSWORD);
  assign wr_en    = PSEL && PENABLE && PWRITE && PREADY;
  assign wr_ok    = wr_en && !(locked && is_guarded(idx)); // RL7
  assign flags_wr = wr_ok && idx == IDX_FLAGS;
  assign irq_wr   = wr_en && idx == IDX_IRQ_STATUS;

  always_comb begin
    next_preset_lo = preset_lo;
    next_preset_hi = preset_hi;
    next_ctrl      = ctrl;
    next_pw_entry  = pw_entry;
    next_irq_mask  = irq_mask;
    if (wr_ok) begin
      case (idx)
        IDX_PRESET_LO: next_preset_lo = PWDATA[LO_W-1:0]; // RL1
        IDX_PRESET_HI: next_preset_hi = PWDATA[HI_W-1:0]; // RL2 RL3
        IDX_CTRL:      next_ctrl      = PWDATA[CTRL_W-1:0];
        IDX_PW_ENTRY:  next_pw_entry  = PWDATA;
        IDX_IRQ_MASK:  next_irq_mask  = PWDATA[FLAG_W-1:0];
        default:       next_ctrl      = ctrl;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      preset_lo <= PRESET_LO_RST;
      preset_hi <= PRESET_HI_RST;
      ctrl      <= CTRL_RST;
      pw_entry  <= PW_RST;
      irq_mask  <= IRQ_RST;
    end else begin
      preset_lo <= next_preset_lo;
      preset_hi <= next_preset_hi;
      ctrl      <= next_ctrl;
      pw_entry  <= next_pw_entry;
      irq_mask  <= next_irq_mask;
    end
  end

  // timer clock selection
  logic fast_tick;
  logic slow_tick;
  logic tick;

  tick_divider #(.DIV(FAST_DIV)) u_fast_div (
    .clk   (CLK),
    .rst_n (rst_n),
    .run   (ctrl[CTRL_TE]),
    .tick  (fast_tick)
  );

  tick_divider #(.DIV(SLOW_DIV)) u_slow_div (
    .clk   (CLK),
    .rst_n (rst_n),
    .run   (ctrl[CTRL_TE]),
    .tick  (slow_tick)
  );

  assign tick = ctrl[CTRL_TSEL] ? slow_tick : fast_tick; // RL6

  // countdown
  cd_state_t           state;
  cd_state_t           next_state;
  logic [PRESET_W-1:0] next_count;
  logic [PRESET_W-1:0] preset;
  logic                expire;
  logic                next_expire;

  assign preset = {preset_hi, preset_lo};

  always_comb begin
    next_state  = state;
    next_count  = count;
    next_expire = 1'b0;
    case (state)
      CD_IDLE: begin
        if (ctrl[CTRL_TE]) begin
          next_state = CD_RUN;
          next_count = preset;
        end
      end
      CD_RUN: begin
        if (!ctrl[CTRL_TE]) begin
          next_state = CD_IDLE;
        end else if (tick) begin
          if (count <= COUNT_ONE) begin
            next_count  = preset; // RL4
            next_expire = (count == COUNT_ONE); // RL5 RL6
          end else begin
            next_count = count - COUNT_ONE; // RL6
          end
        end
      end
      default: next_state = CD_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state  <= CD_IDLE;
      count  <= COUNT_ZERO;
      expire <= 1'b0;
    end else begin
      state  <= next_state;
      count  <= next_count;
      expire <= next_expire;
    end
  end

  // flags and interrupts
  logic [FLAG_W-1:0] events;

  always_comb begin
    events          = FLAG_EVENTS;
    events[FLAG_EXPIRED] = FLAG_EVENTS[FLAG_EXPIRED] | expire; // RL9
  end

  flag_bank #(.W(FLAG_W), .RST(FLAGS_RST), .CLR_ON_ONE(1'b0)) u_flags ( // RL8 RL9
    .clk   (CLK),
    .rst_n (rst_n),
    .set   (events),
    .wr    (flags_wr),
    .wdata (PWDATA[FLAG_W-1:0]),
    .flags (flags)
  );

  flag_bank #(.W(FLAG_W), .RST(IRQ_RST), .CLR_ON_ONE(1'b1)) u_irq (
    .clk   (CLK),
    .rst_n (rst_n),
    .set   (events),
    .wr    (irq_wr),
    .wdata (PWDATA[FLAG_W-1:0]),
    .flags (irq_status)
  );

  // apb answer, data registered in the setup cycle
  logic [DATA_W-1:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_irq;
  logic              setup;

  assign setup = PSEL && !PENABLE;

  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    next_pready  = setup;
    next_irq     = |(irq_status & irq_mask);
    if (setup) begin
      case (idx)
        IDX_PRESET_LO:  next_prdata[LO_W-1:0]   = preset_lo; // RL10
        IDX_PRESET_HI:  next_prdata[HI_W-1:0]   = preset_hi; // RL3 RL10
        IDX_FLAGS:      next_prdata[FLAG_W-1:0] = flags;
        IDX_CTRL:       next_prdata[CTRL_W-1:0] = ctrl;
        IDX_PW_ENTRY:   next_prdata             = '0;
        IDX_IRQ_STATUS: next_prdata[FLAG_W-1:0] = irq_status;
        IDX_IRQ_MASK:   next_prdata[FLAG_W-1:0] = irq_mask;
        IDX_COUNT: begin
          next_prdata[PRESET_W-1:0] = count;
          next_pslverr              = PWRITE;
        end
        default:        next_pslverr = 1'b1;
      endcase
      if (PWRITE && locked && is_guarded(idx)) begin
        next_pslverr = 1'b1; // RL7
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ     <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      IRQ     <= next_irq;
    end
  end

  // checks
  a_low_write: assert property (@(posedge CLK) disable iff (!rst_n) // RL1
    wr_en && !locked && idx == IDX_PRESET_LO |=> preset_lo == $past(PWDATA[LO_W-1:0]))
    else $error("low preset not stored");

  a_high_write: assert property (@(posedge CLK) disable iff (!rst_n) // RL2
    wr_en && !locked && idx == IDX_PRESET_HI |=> preset_hi == $past(PWDATA[HI_W-1:0]))
    else $error("high preset not stored");

  a_high_upper_zero: assert property (@(posedge CLK) disable iff (!rst_n) // RL3
    setup && idx == IDX_PRESET_HI |=> PREADY && PRDATA[DATA_W-1:HI_W] == '0)
    else $error("high preset upper bits not zero");

  a_reload_at_zero: assert property (@(posedge CLK) disable iff (!rst_n) // RL4
    state == CD_RUN && ctrl[CTRL_TE] && tick && count == COUNT_ONE
    |=> count == $past(preset) && expire)
    else $error("preset not reloaded at expiry");

  a_repeat_expiry: assert property (@(posedge CLK) disable iff (!rst_n) // RL5
    expire |-> state == CD_RUN && count == $past(preset))
    else $error("countdown did not restart after expiry");

  a_locked_hold: assert property (@(posedge CLK) disable iff (!rst_n) // RL7
    wr_en && locked && is_guarded(idx) |=> $stable(preset_lo) && $stable(preset_hi))
    else $error("write passed password protection");

  a_no_sw_set: assert property (@(posedge CLK) disable iff (!rst_n) // RL8
    !flags[FLAG_EXPIRED] && !expire && !FLAG_EVENTS[FLAG_EXPIRED] |=> !flags[FLAG_EXPIRED])
    else $error("timer flag set without event");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!rst_n) // RL9
    expire |=> flags[FLAG_EXPIRED] ##1 (flags[FLAG_EXPIRED] || $past(flags_wr)))
    else $error("timer flag not set or lost");

  a_read_preset: assert property (@(posedge CLK) disable iff (!rst_n) // RL10
    setup && idx == IDX_PRESET_LO |=> PRDATA[LO_W-1:0] == $past(preset_lo))
    else $error("preset read not the stored value");

  a_high_read: assert property (@(posedge CLK) disable iff (!rst_n) // RL10
    setup && idx == IDX_PRESET_HI |=> PRDATA[HI_W-1:0] == $past(preset_hi))
    else $error("high preset read not the stored value");

  a_expire_cause: assert property (@(posedge CLK) disable iff (!rst_n) // RL5
    expire |-> $past(tick) && $past(count) == COUNT_ONE)
    else $error("expiry without a completed period");

  a_preset_load: assert property (@(posedge CLK) disable iff (!rst_n) // RL6
    state == CD_IDLE && ctrl[CTRL_TE] |=> state == CD_RUN && count == $past(preset))
    else $error("preset not loaded at enable");

  a_count_step: assert property (@(posedge CLK) disable iff (!rst_n) // RL6
    state == CD_RUN && ctrl[CTRL_TE] && tick && count > COUNT_ONE
    |=> count == $past(count) - COUNT_ONE)
    else $error("count did not step down on tick");

  a_count_hold: assert property (@(posedge CLK) disable iff (!rst_n) // RL6
    state == CD_RUN && ctrl[CTRL_TE] && !tick |=> $stable(count))
    else $error("count moved without a tick");

  a_locked_error: assert property (@(posedge CLK) disable iff (!rst_n) // RL7
    setup && PWRITE && locked && is_guarded(idx) |=> PREADY && PSLVERR)
    else $error("blocked write not flagged");

  a_read_allowed: assert property (@(posedge CLK) disable iff (!rst_n) // RL7
    setup && !PWRITE && is_guarded(idx) |=> PREADY && !PSLVERR)
    else $error("read of a protected register refused");

  a_no_event_rise: assert property (@(posedge CLK) disable iff (!rst_n) // RL8
    events == '0 |=> (flags & ~$past(flags)) == '0)
    else $error("status flag set without event");

  a_flag_clear_zero: assert property (@(posedge CLK) disable iff (!rst_n) // RL9
    flags_wr && !PWDATA[FLAG_EXPIRED] && !events[FLAG_EXPIRED] |=> !flags[FLAG_EXPIRED])
    else $error("timer flag not cleared by zero");

  a_flag_keep_one: assert property (@(posedge CLK) disable iff (!rst_n) // RL9
    flags_wr && PWDATA[FLAG_EXPIRED] && flags[FLAG_EXPIRED] |=> flags[FLAG_EXPIRED])
    else $error("timer flag lost on writing one");
endmodule // countdown_timer

// file: countdown_timer_pkg.sv
/*
  Shared constants of the periodic countdown timer: register indices,
  field positions, reset values and timing figures.
  Assumes a 200 MHz system clock and a word-aligned APB register map.
*/
package countdown_timer_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_PRESET_LO  = 6'h0b;
  localparam logic [5:0] IDX_PRESET_HI  = 6'h0c;
  localparam logic [5:0] IDX_FLAGS      = 6'h0d;
  localparam logic [5:0] IDX_CTRL       = 6'h10;
  localparam logic [5:0] IDX_PW_ENTRY   = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h12;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h13;
  localparam logic [5:0] IDX_COUNT      = 6'h14;

  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int PRESET_W   = 12;
  localparam int LO_W       = 8;
  localparam int HI_W       = 4;
  localparam int FLAG_W     = 8;
  localparam int CTRL_W     = 3;

  // field positions
  localparam int FLAG_EXPIRED = 4;
  localparam int CTRL_TE    = 0;
  localparam int CTRL_TSEL  = 1;
  localparam int CTRL_PROT  = 2;

  // reset values
  localparam logic [LO_W-1:0]     PRESET_LO_RST = 8'h00;
  localparam logic [HI_W-1:0]     PRESET_HI_RST = 4'h0;
  localparam logic [FLAG_W-1:0]   FLAGS_RST     = 8'h02;
  localparam logic [FLAG_W-1:0]   IRQ_RST       = 8'h00;
  localparam logic [CTRL_W-1:0]   CTRL_RST      = 3'h0;
  localparam logic [DATA_W-1:0]   PW_RST        = 32'h0000_0000;
  localparam logic [PRESET_W-1:0] COUNT_ONE     = 12'h001;
  localparam logic [PRESET_W-1:0] COUNT_ZERO    = 12'h000;

  // timing
  localparam int unsigned CLK_HZ  = 200_000_000;
  localparam int unsigned FAST_HZ = 4096;
  localparam int unsigned SLOW_HZ = 1;

  typedef enum logic {CD_IDLE, CD_RUN} cd_state_t;
endpackage

// file: flag_bank.sv
/*
  Bank of sticky flags set by hardware events and cleared by software.
  Assumes set pulses come from event logic; a set always beats a clear.
*/
`timescale 1ns/1ps
module flag_bank #(
  parameter int         W          = 8,
  parameter logic [W-1:0] RST      = '0,
  parameter bit         CLR_ON_ONE = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] flags
);
  logic [W-1:0] clr;
  logic [W-1:0] next_flags;

  always_comb begin
    clr = '0;
    if (wr) begin
      clr = CLR_ON_ONE ? wdata : ~wdata;
    end
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RST;
    end else begin
      flags <= next_flags;
    end
  end
endmodule // flag_bank

// file: tb_countdown_timer.sv
/*
  Self-checking bench of the countdown timer: presets, flags, irq, lock, period.
  Assumes the countdown_timer_pkg package; APB answers must come within the 50-cycle wait limit of the apb task.
*/
`timescale 1ns/1ps
module tb_countdown_timer
  import countdown_timer_pkg::*;
;
  localparam logic [31:0] PW   = 32'h1234_5678; // arbitrary value
  localparam logic [7:0]  A_LO = {IDX_PRESET_LO, 2'b00};
  localparam logic [7:0]  A_HI = {IDX_PRESET_HI, 2'b00};
  localparam logic [7:0]  A_FL = {IDX_FLAGS, 2'b00};
  localparam logic [7:0]  A_CT = {IDX_CTRL, 2'b00};
  localparam logic [7:0]  A_PW = {IDX_PW_ENTRY, 2'b00};
  localparam logic [7:0]  A_IS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0]  A_IM = {IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0]  A_CN = {IDX_COUNT, 2'b00};
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0]  flag_events = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] seed = 32'd90273;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          m_lo;
  int          m_hi;

  countdown_timer #(.FAST_DIV(4), .SLOW_DIV(10), .PASSWORD(PW)) i_countdown_timer (
    .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .FLAG_EVENTS(flag_events), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, d, r, er);
    chk({31'd0, er}, {31'd0, ee});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic        er;
    apb(1'b0, a, '0, r, er);
    chk(r, e);
    chk({31'd0, er}, 32'd0);
  endtask

  task automatic wait_irq(input logic lvl, output int t);
    int n;
    n = 0;
    while (irq !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) num_errors++;
    t = cyc;
  endtask

  task automatic period(input logic [11:0] p, input logic [31:0] c, input int exp);
    int t0;
    int t1;
    wr(A_CT, 32'h0, 1'b0);
    wr(A_LO, {24'd0, p[7:0]}, 1'b0);
    wr(A_HI, {28'd0, p[11:8]}, 1'b0);
    wr(A_IM, 32'h10, 1'b0);
    wr(A_CT, c, 1'b0);
    rd(A_LO, {24'd0, p[7:0]});
    wait_irq(1'b1, t0);
    for (int k = 0; k < 2; k++) begin
      wr(A_IS, 32'h10, 1'b0);
      wait_irq(1'b0, t1);
      wait_irq(1'b1, t1);
      chk(t1 - t0, exp);
      t0 = t1;
    end
    rd(A_HI, {28'd0, p[11:8]});
    wr(A_CT, 32'h0, 1'b0);
    wr(A_IM, 32'h0, 1'b0);
    wr(A_IS, 32'hff, 1'b0);
  endtask

  task automatic pulse(input logic [7:0] b);
    @(posedge clk);
    flag_events <= b;
    @(posedge clk);
    flag_events <= '0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    logic [31:0] v;
    logic [31:0] r;
    logic        er;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_LO, 32'h0);
    rd(A_HI, 32'h0);
    rd(A_FL, 32'h02);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : xs();
      wr(A_LO, v, 1'b0);
      m_lo = int'(v & 32'hff);
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : xs();
      wr(A_HI, v, 1'b0);
      m_hi = int'(v & 32'hf);
      rd(A_LO, m_lo);
      rd(A_HI, m_hi);
    end
    $display("preset access done");
    pulse(8'h08);
    rd(A_FL, 32'h0a);
    wr(A_FL, 32'hff, 1'b0);
    rd(A_FL, 32'h0a);
    wr(A_FL, 32'h00, 1'b0);
    wr(A_FL, 32'hff, 1'b0);
    rd(A_FL, 32'h00);
    wr(A_IM, 32'h08, 1'b0);
    rd(A_IM, 32'h08);
    repeat (3) @(posedge clk);
    chk({31'd0, irq}, 32'd1);
    wr(A_IM, 32'h00, 1'b0);
    repeat (3) @(posedge clk);
    chk({31'd0, irq}, 32'd0);
    wr(A_IM, 32'h08, 1'b0);
    wr(A_IS, 32'h08, 1'b0);
    repeat (3) @(posedge clk);
    chk({31'd0, irq}, 32'd0);
    rd(A_IS, 32'h0);
    wr(A_IM, 32'h00, 1'b0);
    $display("flags and irq done");
    period(12'h102, 32'h1, 258 * 4);
    rd(A_FL, 32'h10);
    wr(A_FL, 32'hff, 1'b0);
    rd(A_FL, 32'h10);
    wr(A_FL, 32'hef, 1'b0);
    rd(A_FL, 32'h00);
    period(12'h005, 32'h3, 5 * 10);
    $display("periodic countdown done");
    wr(A_LO, 32'h33, 1'b0);
    wr(A_CT, 32'h4, 1'b0);
    wr(A_LO, 32'h55, 1'b1);
    wr(A_HI, 32'h7, 1'b1);
    rd(A_LO, 32'h33);
    rd(A_HI, 32'h0);
    rd(A_CT, 32'h4);
    wr(A_PW, PW, 1'b0);
    rd(A_PW, 32'h0);
    wr(A_LO, 32'h55, 1'b0);
    rd(A_LO, 32'h55);
    wr(A_CT, 32'h3, 1'b0);
    rd(A_CN, 32'h55);
    wr(A_CN, 32'h1, 1'b1);
    wr(A_CT, 32'h0, 1'b0);
    wr(8'hfc, 32'h1, 1'b1);
    apb(1'b0, 8'hfc, '0, r, er);
    chk({31'd0, er}, 32'd1);
    $display("protection and map done");
    finish_test();
  end

  initial begin
    #(20000 * 5);
    num_errors++;
    finish_test();
  end
endmodule // tb_countdown_timer

// file: tick_divider.sv
/*
  Divider that turns the system clock into a one-cycle timer tick enable.
  Assumes DIV is at least 1; the tick repeats every DIV cycles while run.
*/
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (!run) begin
      next_count = 32'h0000_0000;
    end else if (count >= DIV - 1) begin
      next_count = 32'h0000_0000;
      next_tick  = 1'b1;
    end else begin
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule // tick_divider
